// File: hdl/i2cst_ctl.sv
// start condition trigger controller with apb registers
//
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
module i2cst_ctl
  import i2cst_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OEN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OEN,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // wire inputs pass two flops before any logic
  logic scl_m, scl_s, sda_m, sda_s, sda_p;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_m <= SCL_IN;
      scl_s <= scl_m;
      sda_m <= SDA_IN;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end
  logic det_start, det_stop;
  assign det_start = scl_s & sda_p & ~sda_s;
  assign det_stop = scl_s & ~sda_p & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  i2cst_state_e state, next_state;
  logic [7:0] cnt, next_cnt, rate, next_rate;
  logic trig, next_trig, en, next_en, resv_dis, next_resv_dis;
  logic fail, next_fail, busy, next_busy;
  logic [EV_W-1:0] stat, next_stat, mask, next_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_scl_oen, next_sda_oen, next_irq;
  logic acc, wr, mapped, arb, ev_start, ev_fail, trig_wr, exit_wr;

  assign acc = PSEL & PENABLE & PREADY;
  assign wr = acc & PWRITE;
  assign mapped = (PADDR == CTRL_ADDR) | (PADDR == FLAG_ADDR) | (PADDR == RATE_ADDR) |
                  (PADDR == STAT_ADDR) | (PADDR == MASK_ADDR) | (PADDR == STATE_ADDR);
  assign trig_wr = wr & (PADDR == CTRL_ADDR) & PWDATA[CTRL_START_BIT];
  assign exit_wr = wr & (PADDR == CTRL_ADDR) & PWDATA[CTRL_EXIT_BIT];
  // a third party pulling data low while we wait to start
  assign arb = (state == ST_SETUP) & scl_s & ~sda_s;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_trig = trig;
    next_en = en;
    next_resv_dis = resv_dis;
    next_rate = rate;
    next_fail = fail;
    next_busy = busy;
    next_mask = mask;
    ev_start = 1'b0;
    ev_fail = 1'b0;
    // one wait state so read data comes from a flop
    next_pready = PSEL & PENABLE & ~PREADY;
    next_pslverr = PSEL & PENABLE & ~PREADY & ~mapped;
    next_prdata = RDATA_RST;
    if (PSEL & PENABLE & ~PREADY & ~PWRITE) begin
      case (PADDR)
        // trigger, stop and exit bits always read zero
        CTRL_ADDR: next_prdata[CTRL_EN_BIT] = en;
        FLAG_ADDR: begin
          next_prdata[FLAG_RESV_DIS_BIT] = resv_dis;
          next_prdata[FLAG_BUSY_BIT] = busy;
          next_prdata[FLAG_FAIL_BIT] = fail;
        end
        RATE_ADDR: next_prdata[7:0] = rate;
        STAT_ADDR: next_prdata[EV_W-1:0] = stat;
        MASK_ADDR: next_prdata[EV_W-1:0] = mask;
        STATE_ADDR: next_prdata[3:0] = {trig, state};
        default: next_prdata = RDATA_RST;
      endcase
    end
    if (wr) begin
      case (PADDR)
        CTRL_ADDR: next_en = PWDATA[CTRL_EN_BIT];
        FLAG_ADDR: next_resv_dis = PWDATA[FLAG_RESV_DIS_BIT];
        RATE_ADDR: next_rate = PWDATA[7:0];
        MASK_ADDR: next_mask = PWDATA[EV_W-1:0];
        default: next_mask = mask;
      endcase
    end
    // bus ownership as seen on the wire, ours included
    if (det_start) begin
      next_busy = 1'b1;
    end else if (det_stop) begin
      next_busy = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        // a pending trigger is the reservation: start once the bus frees
        if (trig & ~busy) begin
          next_state = ST_SETUP;
          next_cnt = 8'h00;
        end
      end
      ST_SETUP: begin
        if (arb) begin
          next_state = ST_IDLE;
        end else if (scl_s & sda_s) begin
          next_cnt = cnt + 8'h01;
          if (cnt >= rate) begin
            next_state = ST_SDA_LOW;
            next_cnt = 8'h00;
          end
        end else begin
          next_cnt = 8'h00;
        end
      end
      ST_SDA_LOW: begin
        next_cnt = cnt + 8'h01;
        if (cnt >= rate) begin
          next_state = ST_WAIT;
          next_cnt = 8'h00;
          ev_start = 1'b1;
        end
      end
      ST_WAIT: begin
        if (trig) begin
          next_state = ST_REL_SDA;
          next_cnt = 8'h00;
        end
      end
      ST_REL_SDA: begin
        // data rises under a low clock, so no stop is made on the way
        next_cnt = cnt + 8'h01;
        if (cnt >= rate) begin
          next_state = ST_SETUP;
          next_cnt = 8'h00;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (trig_wr & en) begin
      if ((state != ST_WAIT) & busy & resv_dis) begin
        ev_fail = 1'b1;
      end else begin
        next_trig = 1'b1;
      end
    end
    // a refused trigger is dropped too, so no stale reservation survives
    if (ev_start | ev_fail | arb | exit_wr) begin
      next_trig = 1'b0;
    end
    if (exit_wr) begin
      next_state = ST_IDLE;
    end
    if (ev_fail) begin
      next_fail = 1'b1;
    end else if (trig_wr & en) begin
      next_fail = 1'b0;
    end
    if (~en) begin
      next_state = ST_IDLE;
      next_trig = 1'b0;
      next_busy = 1'b0;
      next_fail = 1'b0;
      next_cnt = 8'h00;
    end
    // write one to clear, a new event wins over the clear
    next_stat = stat;
    if (wr & (PADDR == STAT_ADDR)) begin
      next_stat = stat & ~PWDATA[EV_W-1:0];
    end
    next_stat[EV_START_BIT] = next_stat[EV_START_BIT] | ev_start;
    next_stat[EV_FAIL_BIT] = next_stat[EV_FAIL_BIT] | ev_fail;
    next_stat[EV_ARB_BIT] = next_stat[EV_ARB_BIT] | arb;
    next_irq = |(next_stat & next_mask);
    next_sda_oen = ~((next_state == ST_SDA_LOW) | (next_state == ST_WAIT));
    next_scl_oen = ~((next_state == ST_WAIT) | (next_state == ST_REL_SDA));
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      trig <= 1'b0;
      en <= 1'b0;
      resv_dis <= 1'b0;
      rate <= RATE_RST;
      fail <= 1'b0;
      busy <= 1'b0;
      stat <= '0;
      mask <= MASK_RST;
      PRDATA <= RDATA_RST;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      SCL_OEN <= 1'b1;
      SDA_OEN <= 1'b1;
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      trig <= next_trig;
      en <= next_en;
      resv_dis <= next_resv_dis;
      rate <= next_rate;
      fail <= next_fail;
      busy <= next_busy;
      stat <= next_stat;
      mask <= next_mask;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      SCL_OEN <= next_scl_oen;
      SDA_OEN <= next_sda_oen;
      // open drain: only ever drives low
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      IRQ <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking dcb @(posedge CLK); endclocking
  default disable iff (SRST);

  AST_NO_TRIG_NO_START: assert property (
    (state == ST_IDLE) && !trig |=> (state == ST_IDLE))
    else $error("start sequence began without a trigger");
  AST_START_ORDER: assert property (
    (state == ST_SETUP) && (next_state == ST_SDA_LOW)
      |-> scl_s && sda_s ##1 !SDA_OEN && SCL_OEN)
    else $error("data not low with clock released during start");
  AST_START_TO_WAIT: assert property (
    (state == ST_SDA_LOW) && (cnt >= rate) && en && !exit_wr
      |=> (state == ST_WAIT) && !SCL_OEN && !SDA_OEN)
    else $error("start hold did not end in the wait state");
  AST_RESERVE_HOLD: assert property (
    (state == ST_IDLE) && trig && busy && en && !exit_wr |=> trig && (state == ST_IDLE))
    else $error("reserved start left idle while bus busy");
  AST_FAIL_NO_RESV: assert property (
    trig_wr && en && busy && resv_dis && (state != ST_WAIT) |=> fail && !trig)
    else $error("refused trigger did not flag failure");
  AST_RESTART: assert property (
    (state == ST_WAIT) && trig && en && !exit_wr
      |=> (state == ST_REL_SDA) && SDA_OEN && !SCL_OEN)
    else $error("wait not released for repeated start");
  AST_ARB_CLEAR: assert property (
    arb && en |=> !trig && (state == ST_IDLE) && stat[EV_ARB_BIT])
    else $error("arbitration loss kept the trigger");
  AST_EXIT_RELEASE: assert property (
    exit_wr |=> (state == ST_IDLE) && !trig && SDA_OEN && SCL_OEN)
    else $error("comm exit did not release the bus");
  AST_CTRL_READ_ZERO: assert property (
    acc && !PWRITE && (PADDR == CTRL_ADDR) |-> !PRDATA[CTRL_START_BIT])
    else $error("start trigger read back non-zero");
  AST_FLAG_LAYOUT: assert property (
    PSEL && PENABLE && !PREADY && !PWRITE && (PADDR == FLAG_ADDR)
      |=> PRDATA[FLAG_RESV_DIS_BIT] == $past(resv_dis) && PRDATA[FLAG_FAIL_BIT] == $past(fail))
    else $error("flag register layout wrong");
  AST_DISABLED_QUIET: assert property (
    !en [*2] |-> SDA_OEN && SCL_OEN && !trig)
    else $error("bus driven while unit disabled");

  COV_START: cover property ((state == ST_SDA_LOW) ##1 (state == ST_WAIT));
  COV_FAIL: cover property (ev_fail);
  COV_RESTART: cover property ((state == ST_REL_SDA) ##1 (state == ST_SETUP));
  COV_ARB: cover property (arb);
  COV_RESERVE: cover property ((state == ST_IDLE) && trig && busy);
endmodule

// File: hdl/i2cst_pkg.sv
// constants of the two-wire start trigger controller
package i2cst_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] FLAG_ADDR = 8'h04;
  localparam logic [7:0] RATE_ADDR = 8'h08;
  localparam logic [7:0] STAT_ADDR = 8'h0C;
  localparam logic [7:0] MASK_ADDR = 8'h10;
  localparam logic [7:0] STATE_ADDR = 8'h14;
  // bus_control_register fields
  localparam int CTRL_STOP_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_EXIT_BIT = 6;
  localparam int CTRL_EN_BIT = 7;
  // bus_flag_register fields
  localparam int FLAG_RESV_DIS_BIT = 0;
  localparam int FLAG_BUSY_BIT = 6;
  localparam int FLAG_FAIL_BIT = 7;
  // interrupt status and mask fields
  localparam int EV_START_BIT = 0;
  localparam int EV_FAIL_BIT = 1;
  localparam int EV_ARB_BIT = 2;
  localparam int EV_W = 3;
  // reset values
  localparam logic [7:0] RATE_RST = 8'h64;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // start sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_SDA_LOW = 3'b010,
    ST_WAIT = 3'b011,
    ST_REL_SDA = 3'b100
  } i2cst_state_e;
endpackage

// File: verification/i2cst_peer.sv
// far-side master model sharing both open-drain bus lines
`timescale 1ns/100ps
module i2cst_peer (
  input wire logic scl_oen,
  input wire logic sda_oen,
  input wire logic busy_req,
  output logic scl,
  output logic sda
);
  logic scl_d = 1'b1;
  logic sda_d = 1'b1;
  // pull-ups: a released line reads high
  assign scl = scl_oen & scl_d;
  assign sda = sda_oen & sda_d;
  // third-party frame: start, clocking, then stop
  always @(posedge busy_req) begin
    sda_d = 1'b0;
    #200;
    // link clock runs only inside the frame
    while (busy_req) begin
      scl_d = 1'b0;
      #200;
      scl_d = 1'b1;
      #200;
    end
    sda_d = 1'b1;
  end
endmodule

// File: verification/testbench.sv
// self-checking bench of the start trigger controller
`timescale 1ns/100ps
module testbench;
  import i2cst_pkg::*;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, SCL_OUT, SCL_OEN, SDA_OUT, SDA_OEN, IRQ, scl, sda;
  logic busy_req = 1'b0;
  logic [32:0] exp_q[$];
  int fail_count = 0;
  int checked = 0;
  logic [7:0] rate;
  always #25 CLK = ~CLK;
  i2cst_ctl uut (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SCL_IN(scl), .SCL_OUT(SCL_OUT), .SCL_OEN(SCL_OEN), .SDA_IN(sda), .SDA_OUT(SDA_OUT),
    .SDA_OEN(SDA_OEN), .IRQ(IRQ));
  i2cst_peer peer (.scl_oen(SCL_OEN), .sda_oen(SDA_OEN), .busy_req(busy_req), .scl(scl),
    .sda(sda));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [32:0] seen, input logic [32:0] want);
    checked++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task print_verdict;
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // master never assumes a latency; bounded wait on pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      fail_count++;
      print_verdict;
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [32:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // read results compared against the oldest note
  always @(posedge CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
      chk({PSLVERR, PRDATA}, exp_q.pop_front());
  end
  task wait_oen(input bit on_scl, input logic v);
    int n;
    n = 0;
    while ((on_scl ? SCL_OEN : SDA_OEN) !== v && n < 3000) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 3000) begin
      fail_count++;
      print_verdict;
    end
  endtask
  // data line must stay released for the whole span
  task quiet(input int cyc);
    logic low;
    low = 1'b0;
    repeat (cyc) begin
      @(posedge CLK);
      low = low | ~SDA_OEN;
    end
    chk({32'h0, low}, 33'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(33249));
    rate = 8'(1 + $urandom % 3);
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    rd(RATE_ADDR, {25'h0, RATE_RST});
    rd(MASK_ADDR, 33'h0);
    rd(8'h18, 33'h1_0000_0000);
    apb(1'b1, RATE_ADDR, {24'h0, rate});
    rd(RATE_ADDR, {25'h0, rate});
    apb(1'b1, CTRL_ADDR, 32'h0000_0002);
    quiet(100);
    apb(1'b1, CTRL_ADDR, 32'h0000_0080);
    quiet(100);
    apb(1'b1, CTRL_ADDR, 32'h0000_0082);
    wait_oen(1'b0, 1'b0);
    chk({32'h0, scl}, 33'h1);
    wait_oen(1'b1, 1'b0);
    rd(CTRL_ADDR, 33'h80);
    chk({32'h0, IRQ}, 33'h0);
    apb(1'b1, MASK_ADDR, 32'h0000_0001);
    repeat (2) @(posedge CLK);
    chk({32'h0, IRQ}, 33'h1);
    apb(1'b1, STAT_ADDR, 32'h0000_0001);
    repeat (2) @(posedge CLK);
    chk({32'h0, IRQ}, 33'h0);
    // restart only from the wait state, on a fresh trigger write
    apb(1'b1, CTRL_ADDR, 32'h0000_0082);
    wait_oen(1'b0, 1'b1);
    wait_oen(1'b0, 1'b0);
    chk({32'h0, scl}, 33'h1);
    wait_oen(1'b1, 1'b0);
    apb(1'b1, CTRL_ADDR, 32'h0000_00C0);
    wait_oen(1'b1, 1'b1);
    chk({32'h0, SDA_OEN}, 33'h1);
    apb(1'b1, FLAG_ADDR, 32'h0000_0001);
    busy_req <= 1'b1;
    repeat (20) @(posedge CLK);
    apb(1'b1, CTRL_ADDR, 32'h0000_0082);
    quiet(20);
    rd(FLAG_ADDR, 33'hC1);
    rd(CTRL_ADDR, 33'h80);
    apb(1'b1, FLAG_ADDR, 32'h0000_0000);
    apb(1'b1, CTRL_ADDR, 32'h0000_0082);
    rd(STATE_ADDR, 33'h8);
    apb(1'b1, CTRL_ADDR, 32'h0000_0000);
    rd(STATE_ADDR, 33'h0);
    // re-enabled mid-frame the unit misses the start, so its trigger meets the frame
    apb(1'b1, CTRL_ADDR, 32'h0000_0080);
    apb(1'b1, CTRL_ADDR, 32'h0000_0082);
    repeat (20) @(posedge CLK);
    rd(STAT_ADDR, 33'h7);
    rd(STATE_ADDR, 33'h0);
    apb(1'b1, STAT_ADDR, 32'h0000_0007);
    busy_req <= 1'b0;
    repeat (20) @(posedge CLK);
    busy_req <= 1'b1;
    repeat (20) @(posedge CLK);
    apb(1'b1, CTRL_ADDR, 32'h0000_0082);
    quiet(20);
    rd(STATE_ADDR, 33'h8);
    busy_req <= 1'b0;
    wait_oen(1'b0, 1'b0);
    wait_oen(1'b1, 1'b0);
    SRST <= 1'b1;
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    rd(STATE_ADDR, 33'h0);
    chk({31'h0, SCL_OEN, SDA_OEN}, 33'h3);
    chk({31'h0, SCL_OUT, SDA_OUT}, 33'h0);
    print_verdict;
  end
endmodule
